// ---- common/rssm_map.vh ----
// Register map, field positions, reset values and timing counts
`ifndef RSSM_MAP_VH
`define RSSM_MAP_VH

// Special-function addresses and page
`define RSSM_CAUSE_ADDR      8'hef
`define RSSM_SUPPLY_ADDR     8'hff
`define RSSM_SFR_PAGE        4'h0

// Reset cause and enable register fields
`define RSSM_RTC_BIT         7
`define RSSM_FLASH_BIT       6
`define RSSM_CMP_BIT         5
`define RSSM_SOFT_BIT        4
`define RSSM_WDT_BIT         3
`define RSSM_CLKLOSS_BIT     2
`define RSSM_POWER_BIT       1
`define RSSM_PIN_BIT         0
`define RSSM_CAUSE_RST       8'h02

// Supply monitor control register fields
`define RSSM_MON_ON_BIT      7
`define RSSM_ABOVE_RST_BIT   6
`define RSSM_ABOVE_WARN_BIT  5
`define RSSM_RSVD_MSB        4
`define RSSM_MON_ON_RST      1'b1
`define RSSM_RSVD_RST        5'h00

// Timing: clock period, least reset hold, clock loss window
`define RSSM_CLK_NS          10
`define RSSM_HOLD_NS         100
`define RSSM_HOLD_CYC \
  ((`RSSM_HOLD_NS + `RSSM_CLK_NS - 1) / `RSSM_CLK_NS)
`define RSSM_CLKLOSS_NS      20000
`define RSSM_CLKLOSS_CYC \
  ((`RSSM_CLKLOSS_NS + `RSSM_CLK_NS - 1) / `RSSM_CLK_NS)

`endif

// ---- core/rssm_hold_timer.v ----
// Least-duration timer for holding the system in reset
`timescale 1ns/10ps
`include "rssm_map.vh"

module rssm_hold_timer (
  input  wire       clk,
  input  wire       srst,
  input  wire       start,
  output wire       done
);

  // Full-width count first, then cut to the counter width on purpose
  localparam [31:0] HOLD_FULL  = `RSSM_HOLD_CYC;
  localparam [7:0]  HOLD_COUNT = HOLD_FULL[7:0];

  reg [7:0] count;

  // Load on start, then count down to zero
  always @(posedge clk) begin
    if (srst) begin
      count <= 8'h00;
    end else if (start) begin
      count <= HOLD_COUNT;
    end else if (count != 8'h00) begin
      count <= count - 8'h01;
    end
  end

  assign done = (count == 8'h00);

endmodule

// ---- core/rssm_clk_watch.v ----
// Clock loss detector: flags a level that stays put too long
`timescale 1ns/10ps
`include "rssm_map.vh"

module rssm_clk_watch (
  input  wire       clk,
  input  wire       srst,
  input  wire       enable,
  input  wire       watchedLevel,
  output reg        timeout
);

  // Full-width window first, then cut to the counter width on purpose
  localparam [31:0] LIMIT_FULL = `RSSM_CLKLOSS_CYC;
  localparam [11:0] LIMIT      = LIMIT_FULL[11:0];

  reg        lastLevel;
  reg [11:0] stillCount;

  // Any edge on the watched clock restarts the window
  always @(posedge clk) begin
    if (srst) begin
      lastLevel  <= 1'b0;
      stillCount <= 12'h000;
      timeout    <= 1'b0;
    end else begin
      lastLevel <= watchedLevel;
      if (!enable || (watchedLevel != lastLevel)) begin
        stillCount <= 12'h000;
        timeout    <= 1'b0;
      end else if (stillCount != LIMIT) begin
        stillCount <= stillCount + 12'h001;
        timeout    <= 1'b0;
      end else begin
        timeout    <= 1'b1;
      end
    end
  end

endmodule

// ---- core/rssm_top.v ----
// Reset cause capture, reset source enables and supply monitor control
//
// Functional notes
// - Bit 7 reads RTC caused reset; writing 1 enables RTC reset source.
// - Bit 6 read-only, reads 1 only after a flash error reset.
// - Bit 5 reads comparator reset; writing 1 enables active-low comparator.
// - Writing 1 to bit 4 forces reset; bit then reads 1.
// - Bit 3 read-only, reads 1 only after a watchdog overflow reset.
// - Bit 2 reads clock loss reset; writing 1 enables clock loss detector.
// - Bit 1 reads power/supply reset; writing 1 selects supply monitor.
// - Bit 0 read-only, reads 1 only after external pin reset.
// - Reads return last cause; writes only set enables or force reset.
// - When power flag reads 1, other flags are undefined.
// - Cause register sits at address 0xEF, page 0x0.
// - Bit 7 turns monitor on; resets need it selected too.
// - Bit 6 reads 1 while supply above reset threshold.
// - Bit 5 reads 1 while supply above warning threshold.
// - Every other kind of reset clears the power flag.
// - Monitor enable and its selection survive all device resets.
// - Power and supply resets drive reset pin low until exit.
// - Clock loss detector resets when clock stalls past window.
`timescale 1ns/10ps
`include "rssm_map.vh"

//////////////////////////////////////////////////////////////////////////
// Register layout, page 0 only; other pages read zero, drop writes
//
// Cause and enable register at 0xef; read and write reach
// different logic:
//   bit  read                        write 1
//   7    RTC alarm or osc fail       lets RTC events reset
//   6    flash fault                 ignored
//   5    comparator low              lets comparator reset
//   4    forced by software          forces a reset now
//   3    watchdog overflow           ignored
//   2    clock loss timeout          arms clock loss watch
//   1    power-up or supply drop     selects supply monitor
//   0    reset pin held low          ignored
// Writing 0 to bits 7, 5, 2 or 1 turns that source off again.
//
// Supply monitor control register at 0xff:
//   7    monitor on, survives device resets
//   6    supply above reset level, live comparator
//   5    supply above warning level, live comparator
//   4:0  stored as written; zero is the only legal value
//
// Reads have no side effects; back-to-back accesses are fine.
// Limitation: the RTC, comparator and clock loss enables fall back
// to off on every device reset, so boot code must rewrite them.
// Of the resets, only srst, standing for a full power-up, sets the supply monitor
// on and selected again.

module rssm_top (
  input  wire       clk,
  input  wire       srst,
  // Special-function register access from the core
  input  wire [3:0] sfrPage,
  input  wire [7:0] sfrAddr,
  input  wire       sfrRead,
  input  wire       sfrWrite,
  input  wire [7:0] sfrWdata,
  output reg  [7:0] sfrRdata,
  // Event inputs from neighbouring blocks
  input  wire       powerOnEvent,
  input  wire       supplyAboveResetLevel,
  input  wire       supplyAboveWarningLevel,
  input  wire       rtcAlarm,
  input  wire       rtcOscFail,
  input  wire       comparatorOut,
  input  wire       watchdogOverflow,
  input  wire       flashFault,
  input  wire       watchedClockLevel,
  // External reset pin, open drain
  input  wire       externalResetIn_n,
  output reg        externalResetOut,
  output reg        externalResetOe,
  // System reset and monitor state
  output reg        systemReset,
  output reg        supplyMonitorOn
);

  localparam RUN  = 1'b0;
  localparam HOLD = 1'b1;

  reg       state;
  reg [7:0] causeFlags;      // Value seen by reads
  reg [7:0] pendingCause;    // Cause collected during reset
  reg       rtcEnable;
  reg       comparatorEnable;
  reg       clockLossEnable;
  reg       supplySelected;
  reg [4:0] reservedBits;
  reg       holdStart;
  reg [7:0] next_cause;

  wire       holdDone;
  wire       holdOver;
  wire       clockLossTimeout;
  wire       pageHit;
  wire       causeHit;
  wire       supplyHit;
  wire       causeWrite;
  wire       supplyWrite;
  wire       powerEvent;
  wire       rtcEvent;
  wire       comparatorEvent;
  wire       softEvent;
  wire       anyEvent;
  wire [7:0] supplyReadback;

  //////////////////////////////////////////////////////////////////////////
  // Helpers

  rssm_hold_timer holdTimer (
    .clk   (clk),
    .srst  (srst),
    .start (holdStart),
    .done  (holdDone)
  );

  rssm_clk_watch clockWatch (
    .clk          (clk),
    .srst         (srst),
    .enable       (clockLossEnable),
    .watchedLevel (watchedClockLevel),
    .timeout      (clockLossTimeout)
  );

  //////////////////////////////////////////////////////////////////////////
  // Address decode; writes are ignored while the system is in reset

  // Exact compare of page and address; neither register is mirrored
  assign pageHit     = (sfrPage == `RSSM_SFR_PAGE);
  assign causeHit    = pageHit && (sfrAddr == `RSSM_CAUSE_ADDR);
  assign supplyHit   = pageHit && (sfrAddr == `RSSM_SUPPLY_ADDR);
  assign causeWrite  = sfrWrite && causeHit && (state == RUN);
  assign supplyWrite = sfrWrite && supplyHit && (state == RUN);

  //////////////////////////////////////////////////////////////////////////
  // Reset sources; RTC, comparator and supply drop each gated by its enable

  // Monitor must be both on and selected before it can reset
  assign powerEvent = powerOnEvent ||
                      (supplyMonitorOn && supplySelected &&
                       !supplyAboveResetLevel);
  assign rtcEvent        = rtcEnable && (rtcAlarm || rtcOscFail);
  assign comparatorEvent = comparatorEnable && !comparatorOut;
  assign softEvent       = causeWrite && sfrWdata[`RSSM_SOFT_BIT];
  assign anyEvent = powerEvent || !externalResetIn_n || clockLossTimeout ||
                    watchdogOverflow || flashFault || comparatorEvent ||
                    rtcEvent || softEvent;

  // One-hot cause; when several fire in one cycle, highest first:
  // power, pin, clock loss, watchdog, flash, comparator, RTC, software.
  // Power wins since it also pulls the pin and has the slowest release.
  always @* begin
    next_cause = 8'h00;
    if (powerEvent) begin
      next_cause[`RSSM_POWER_BIT] = 1'b1;
    end else if (!externalResetIn_n) begin
      next_cause[`RSSM_PIN_BIT] = 1'b1;
    end else if (clockLossTimeout) begin
      next_cause[`RSSM_CLKLOSS_BIT] = 1'b1;
    end else if (watchdogOverflow) begin
      next_cause[`RSSM_WDT_BIT] = 1'b1;
    end else if (flashFault) begin
      next_cause[`RSSM_FLASH_BIT] = 1'b1;
    end else if (comparatorEvent) begin
      next_cause[`RSSM_CMP_BIT] = 1'b1;
    end else if (rtcEvent) begin
      next_cause[`RSSM_RTC_BIT] = 1'b1;
    end else if (softEvent) begin
      next_cause[`RSSM_SOFT_BIT] = 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Reset sequencer

  // Timer loads one edge after the start strobe, so its done flag is
  // stale in the first held cycle; the strobe masks it there.
  assign holdOver = holdDone && !holdStart;

  // Cycle walk for a flash fault taken at edge 0:
  //   edge 0   enter HOLD, systemReset high, timer start strobe
  //   edge 1   timer loads the hold count
  //   edge 11  timer reaches zero
  //   edge 12  exit, systemReset low, cause flags loaded
  // A power cause is exempt from the pin wait, because the low level
  // on the pin is then our own pull.

  // Holds reset for a least time, longer while a power event or a low pin persists
  always @(posedge clk) begin
    if (srst) begin
      state            <= RUN;
      systemReset      <= 1'b0;
      externalResetOut <= 1'b0;
      externalResetOe  <= 1'b0;
      holdStart        <= 1'b0;
      pendingCause     <= 8'h00;
      causeFlags       <= `RSSM_CAUSE_RST;
      rtcEnable        <= 1'b0;
      comparatorEnable <= 1'b0;
      clockLossEnable  <= 1'b0;
    end else begin
      holdStart        <= 1'b0;
      externalResetOut <= 1'b0;
      case (state)
        RUN: begin
          if (anyEvent) begin
            state           <= HOLD;
            systemReset     <= 1'b1;
            holdStart       <= 1'b1;
            pendingCause    <= next_cause;
            externalResetOe <= next_cause[`RSSM_POWER_BIT];
            // Device reset returns these enables to off
            rtcEnable        <= 1'b0;
            comparatorEnable <= 1'b0;
            clockLossEnable  <= 1'b0;
          end else if (causeWrite) begin
            // Writes reach only the enables, not the flags
            rtcEnable        <= sfrWdata[`RSSM_RTC_BIT];
            comparatorEnable <= sfrWdata[`RSSM_CMP_BIT];
            clockLossEnable  <= sfrWdata[`RSSM_CLKLOSS_BIT];
          end
        end
        HOLD: begin
          if (powerEvent) begin
            // A supply drop during another reset takes over
            pendingCause    <= 8'h00 | (8'h01 << `RSSM_POWER_BIT);
            externalResetOe <= 1'b1;
          end else if (holdOver &&
                       (externalResetIn_n ||
                        pendingCause[`RSSM_POWER_BIT])) begin
            // Pin is ours while power holds, so it is not waited on
            state           <= RUN;
            systemReset     <= 1'b0;
            externalResetOe <= 1'b0;
            causeFlags      <= pendingCause;
          end
        end
        default: begin
          state       <= RUN;
          systemReset <= 1'b0;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Persistent supply monitor state, touched only by srst and writes

  // Device resets leave the monitor alone
  always @(posedge clk) begin
    if (srst) begin
      supplyMonitorOn <= `RSSM_MON_ON_RST;
      supplySelected  <= 1'b1;
      reservedBits    <= `RSSM_RSVD_RST;
    end else begin
      if (supplyWrite) begin
        supplyMonitorOn <= sfrWdata[`RSSM_MON_ON_BIT];
        reservedBits    <= sfrWdata[`RSSM_RSVD_MSB:0];
      end
      if (causeWrite) begin
        // Selecting an unsettled monitor can reset at once
        supplySelected <= sfrWdata[`RSSM_POWER_BIT];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Read data, registered one cycle after the read strobe

  assign supplyReadback = {supplyMonitorOn,
                           supplyAboveResetLevel,
                           supplyAboveWarningLevel,
                           reservedBits};

  // Reads see only latched flags, never the enables, so software that
  // read-modify-writes the cause register turns causes into enables.
  // Unmapped reads answer zero; reads have no side effects
  always @(posedge clk) begin
    if (srst) begin
      sfrRdata <= 8'h00;
    end else if (sfrRead) begin
      if (causeHit) begin
        sfrRdata <= causeFlags;
      end else if (supplyHit) begin
        sfrRdata <= supplyReadback;
      end else begin
        sfrRdata <= 8'h00;
      end
    end
  end

endmodule

// ---- test/rssm_props.sv ----
// Concurrent checks on the reset cause and supply monitor block
`timescale 1ns/10ps
module rssm_props (
  input logic       clk,
  input logic       srst,
  input logic [3:0] sfrPage,
  input logic [7:0] sfrAddr,
  input logic       sfrRead,
  input logic       sfrWrite,
  input logic [7:0] sfrWdata,
  input logic [7:0] sfrRdata,
  input logic       powerOnEvent,
  input logic       supplyAboveResetLevel,
  input logic       supplyAboveWarningLevel,
  input logic       watchdogOverflow,
  input logic       flashFault,
  input logic       externalResetIn_n,
  input logic       externalResetOut,
  input logic       externalResetOe,
  input logic       systemReset,
  input logic       supplyMonitorOn
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  ////////////////////////////////////////////////////////////////////////////
  // Decodes; only page zero answers
  wire hitCause  = sfrPage == 4'h0 && sfrAddr == 8'hef;
  wire hitSupply = sfrPage == 4'h0 && sfrAddr == 8'hff;
  wire softWr    = sfrWrite && hitCause && sfrWdata[4] && !systemReset;
  ////////////////////////////////////////////////////////////////////////////
  chk_soft_force: assert property (
    softWr |=> systemReset) else $error("forced reset missing");
  chk_flash_entry: assert property (
    flashFault && !systemReset |=> systemReset) else $error("flash no reset");
  chk_wdog_entry: assert property (
    watchdogOverflow && !systemReset |=> systemReset)
    else $error("watchdog no reset");
  chk_pin_entry: assert property (
    !externalResetIn_n && !systemReset |=> systemReset)
    else $error("pin no reset");
  // Power cause must pull the pin with the reset itself
  chk_power_pin: assert property (
    powerOnEvent && !systemReset |=> systemReset && externalResetOe)
    else $error("power reset pin idle");
  chk_soft_pin_idle: assert property (
    softWr && supplyAboveResetLevel && !powerOnEvent && externalResetIn_n
    |=> !externalResetOe) else $error("soft reset drove pin");
  chk_pin_release: assert property (
    $fell(systemReset) |-> !externalResetOe && !externalResetOut)
    else $error("pin held after exit");
  chk_supply_read: assert property (
    sfrRead && hitSupply |=> sfrRdata[7:5] == {$past(supplyMonitorOn),
    $past(supplyAboveResetLevel), $past(supplyAboveWarningLevel)})
    else $error("supply status wrong");
  chk_unmapped_zero: assert property (
    sfrRead && !hitCause && !hitSupply |=> sfrRdata == 8'h00)
    else $error("unmapped read not zero");
  // Held reset must last well past its entry edge
  chk_hold_least: assert property (
    $rose(systemReset) |-> systemReset[*8]) else $error("reset too short");
  cover property ($rose(externalResetOe));
  cover property (softWr ##1 systemReset);
  cover property ($fell(systemReset));
endmodule

bind rssm_top rssm_props i_props (.clk(clk), .srst(srst),
  .sfrPage(sfrPage), .sfrAddr(sfrAddr), .sfrRead(sfrRead),
  .sfrWrite(sfrWrite), .sfrWdata(sfrWdata), .sfrRdata(sfrRdata),
  .powerOnEvent(powerOnEvent), .supplyAboveResetLevel(supplyAboveResetLevel),
  .supplyAboveWarningLevel(supplyAboveWarningLevel),
  .watchdogOverflow(watchdogOverflow), .flashFault(flashFault),
  .externalResetIn_n(externalResetIn_n), .externalResetOut(externalResetOut),
  .externalResetOe(externalResetOe), .systemReset(systemReset),
  .supplyMonitorOn(supplyMonitorOn));

// ---- test/rssm_core_model.sv ----
// Processor core model issuing register accesses to the block
`timescale 1ns/10ps
module rssm_core_model (
  input  logic       clk,
  output logic [3:0] sfrPage,
  output logic [7:0] sfrAddr,
  output logic       sfrRead,
  output logic       sfrWrite,
  output logic [7:0] sfrWdata,
  input  logic [7:0] sfrRdata
);
  initial begin
    sfrPage = 4'h0;
    sfrAddr = 8'h00;
    sfrRead = 1'b0;
    sfrWrite = 1'b0;
    sfrWdata = 8'h00;
  end
  // Released bus shows inverted values so stale data cannot pass
  task automatic release_bus();
    sfrRead = 1'b0;
    sfrWrite = 1'b0;
    sfrPage = ~sfrPage;
    sfrAddr = ~sfrAddr;
    sfrWdata = ~sfrWdata;
  endtask
  // Whole planned bytes only, never merged with a read-back
  task automatic write(input logic [3:0] pg, input logic [7:0] a,
                       input logic [7:0] d);
    sfrPage = pg;
    sfrAddr = a;
    sfrWdata = d;
    sfrWrite = 1'b1;
    @(posedge clk);
    #1;
    release_bus();
    // Idle edge keeps two calls from retoggling the strobe at once
    @(posedge clk);
    #1;
  endtask
  // Data is registered on the strobe edge, taken just after it
  task automatic read(input logic [3:0] pg, input logic [7:0] a,
                      output logic [7:0] d);
    sfrPage = pg;
    sfrAddr = a;
    sfrRead = 1'b1;
    @(posedge clk);
    #1;
    d = sfrRdata;
    release_bus();
    // Idle edge keeps two calls from retoggling the strobe at once
    @(posedge clk);
    #1;
  endtask
endmodule

// ---- test/rssm_top_test.sv ----
// Self-checking bench for the reset cause and supply monitor block
`timescale 1ns/10ps
module rssm_top_test;
  logic clk, srst, powerOnEvent, supAbove, warnAbove, rtcAlarm, stall;
  logic cmpOut, watchdogOverflow, flashFault, watchLvl, pinDrive_n, rtcFail;
  logic [3:0] sfrPage;
  logic [7:0] sfrAddr, sfrWdata, sfrRdata;
  logic sfrRead, sfrWrite, rstOut, rstOe, systemReset, monOn;
  int errCount, numChecks;
  // Open-drain pin: device pull wins over the external pull-up
  wire resetPin_n = rstOe ? rstOut : pinDrive_n;
  rssm_core_model i_core (.clk(clk), .sfrPage(sfrPage), .sfrAddr(sfrAddr),
    .sfrRead(sfrRead), .sfrWrite(sfrWrite), .sfrWdata(sfrWdata),
    .sfrRdata(sfrRdata));
  rssm_top i_dut (.clk(clk), .srst(srst), .sfrPage(sfrPage),
    .sfrAddr(sfrAddr), .sfrRead(sfrRead), .sfrWrite(sfrWrite),
    .sfrWdata(sfrWdata), .sfrRdata(sfrRdata), .powerOnEvent(powerOnEvent),
    .supplyAboveResetLevel(supAbove), .supplyAboveWarningLevel(warnAbove),
    .rtcAlarm(rtcAlarm), .rtcOscFail(rtcFail), .comparatorOut(cmpOut),
    .watchdogOverflow(watchdogOverflow), .flashFault(flashFault),
    .watchedClockLevel(watchLvl), .externalResetIn_n(resetPin_n),
    .externalResetOut(rstOut), .externalResetOe(rstOe),
    .systemReset(systemReset), .supplyMonitorOn(monOn));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Watched clock toggles unless a scenario stalls it
  always @(posedge clk) if (!stall) watchLvl <= ~watchLvl;
  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d mismatches %0d", numChecks, errCount);
    if (errCount == 0 && numChecks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(string what, logic [7:0] exp, logic [7:0] got);
    numChecks++;
    if (got !== exp) begin
      errCount++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Bounded wait for the reset level; running out ends the run
  task automatic wait_level(logic lvl, int bound);
    int n = 0;
    while (systemReset !== lvl && n < bound) begin
      tick(1);
      n++;
    end
    if (systemReset !== lvl) begin
      check("systemReset", 8'(lvl), 8'(systemReset));
      summarize();
    end
  endtask
  task automatic expect_exit(logic [7:0] cause);
    logic [7:0] v;
    wait_level(1'b0, 400);
    i_core.read(4'h0, 8'hef, v);
    check("cause", cause, v);
  endtask
  // One-cycle event pulse; reset must be high one edge after the pulse ends
  task automatic fire(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
    tick(1);
    check("systemReset", 8'h01, 8'(systemReset));
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_defaults();
    logic [7:0] v;
    i_core.read(4'h0, 8'hef, v);
    check("cause", 8'h02, v);
    i_core.read(4'h0, 8'hff, v);
    check("supply", 8'he0, v);
    warnAbove = 1'b0;
    i_core.read(4'h0, 8'hff, v);
    check("supply", 8'hc0, v);
    warnAbove = 1'b1;
    i_core.read(4'h0, 8'h80, v);
    check("unmapped", 8'h00, v);
    i_core.read(4'h1, 8'hef, v);
    check("page", 8'h00, v);
    cmpOut = 1'b0;
    tick(2);
    cmpOut = 1'b1;
    check("systemReset", 8'h00, 8'(systemReset));
    $display("test defaults done");
  endtask
  task automatic t_sources();
    i_core.write(4'h0, 8'hef, 8'h12);
    check("systemReset", 8'h01, 8'(systemReset));
    expect_exit(8'h10);
    rtcAlarm = 1'b1;
    tick(3);
    rtcAlarm = 1'b0;
    check("systemReset", 8'h00, 8'(systemReset));
    fire(flashFault);
    expect_exit(8'h40);
    fire(watchdogOverflow);
    expect_exit(8'h08);
    i_core.write(4'h0, 8'hef, 8'ha6);
    fire(rtcAlarm);
    expect_exit(8'h80);
    i_core.write(4'h0, 8'hef, 8'h82);
    fire(rtcFail);
    expect_exit(8'h80);
    i_core.write(4'h0, 8'hef, 8'h22);
    cmpOut = 1'b0;
    tick(2);
    cmpOut = 1'b1;
    expect_exit(8'h20);
    $display("test sources done");
  endtask
  // Clock loss must not fire early, then must fire near its window
  task automatic t_clock_loss();
    i_core.write(4'h0, 8'hef, 8'h06);
    stall = 1'b1;
    tick(1900);
    check("systemReset", 8'h00, 8'(systemReset));
    wait_level(1'b1, 300);
    stall = 1'b0;
    expect_exit(8'h04);
    pinDrive_n = 1'b0;
    tick(20);
    check("resetOe", 8'h00, 8'(rstOe));
    pinDrive_n = 1'b1;
    expect_exit(8'h01);
    $display("test clock loss and pin done");
  endtask
  task automatic t_supply();
    logic [7:0] v;
    powerOnEvent = 1'b1;
    tick(3);
    check("resetOe", 8'h01, 8'(rstOe));
    powerOnEvent = 1'b0;
    expect_exit(8'h02);
    i_core.write(4'h0, 8'hff, 8'h00);
    check("monOn", 8'h00, 8'(monOn));
    i_core.write(4'h0, 8'hef, 8'h10);
    expect_exit(8'h10);
    i_core.read(4'h0, 8'hff, v);
    check("supply", 8'h60, v);
    supAbove = 1'b0;
    tick(4);
    check("systemReset", 8'h00, 8'(systemReset));
    supAbove = 1'b1;
    i_core.write(4'h0, 8'hff, 8'h80);
    check("monOn", 8'h01, 8'(monOn));
    tick(5);
    i_core.write(4'h0, 8'hef, 8'h02);
    supAbove = 1'b0;
    tick(20);
    check("resetOe", 8'h01, 8'(rstOe));
    supAbove = 1'b1;
    expect_exit(8'h02);
    $display("test supply done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {powerOnEvent, rtcAlarm, flashFault, watchdogOverflow, stall} = 5'h00;
    rtcFail = 1'b0;
    {supAbove, warnAbove, cmpOut, pinDrive_n, srst} = 5'h1f;
    watchLvl = 1'b0;
    errCount = 0;
    numChecks = 0;
    tick(12);
    srst = 1'b0;
    t_defaults();
    t_sources();
    t_clock_loss();
    t_supply();
    summarize();
  end
endmodule
